/* File: core/usc_pkg.sv */
package usc_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_USB_GLOBAL_CONTROL = 6'h33;
  localparam logic [5:0] IDX_LINE_MANUAL_CONTROL = 6'h34;
  localparam logic [5:0] IDX_LINE_PIN_CONFIG = 6'h35;
  localparam logic [5:0] IDX_ENDPOINT0_CONTROL = 6'h36;
  localparam logic [5:0] IDX_ENDPOINT0_COUNT = 6'h37;
  localparam int APB_ADDR_W = 8;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int GC_ENABLE = 7;
  localparam int MC_TX_ENABLE = 7;
  localparam int MC_FORCE_SE0 = 6;
  localparam int MC_LINE_STATE = 5;
  localparam int MC_RECEIVER = 0;
  localparam int PC_PIN_MODE = 7;
  localparam int PC_DRIVE_STYLE = 6;
  localparam int PC_DPLUS_DRIVE = 5;
  localparam int PC_DMINUS_DRIVE = 4;
  localparam int PC_DUAL_PULLUP = 3;
  localparam int PC_BUS_PULLUP = 2;
  localparam int PC_DPLUS_LEVEL = 1;
  localparam int PC_DMINUS_LEVEL = 0;
  localparam int EC_SETUP = 7;
  localparam int EC_IN = 6;
  localparam int EC_OUT = 5;
  localparam int EC_ACKED = 4;
  localparam int CN_TOGGLE = 7;
  localparam int CN_VALID = 6;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GLOBAL_CONTROL = 8'h00;
  localparam logic [2:0] RST_MANUAL_CONTROL = 3'h0;
  localparam logic [5:0] RST_PIN_CONFIG = 6'h00;
  localparam logic [3:0] RST_EP0_MODE = 4'h0;
  localparam logic [3:0] RST_EP0_COUNT = 4'h0;
  localparam logic RST_LINE_LEVEL = 1'b1;

  typedef enum logic [1:0] {
    USC_OWNER_ENGINE,
    USC_OWNER_MANUAL,
    USC_OWNER_PINCFG
  } usc_owner_t;

endpackage

/* File: core/usc_sie_control.sv */
module usc_sie_control
  import usc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tokenValid,
  input wire logic [6:0] tokenAddr,
  input wire logic tokenEp0,
  input wire logic evSetupAck,
  input wire logic evInToken,
  input wire logic evOutPacket,
  input wire logic evOutAck,
  input wire logic evXferDone,
  input wire logic evXferOk,
  input wire logic modeLoad,
  input wire logic [3:0] modeValue,
  input wire logic countLoad,
  input wire logic [3:0] countValue,
  input wire logic toggleLoad,
  input wire logic toggleValue,
  input wire logic sieDpOut,
  input wire logic sieDmOut,
  input wire logic sieDriveEn,
  output logic engineRespond,
  output logic [3:0] ep0Mode,
  output logic ep0Toggle,
  output logic [3:0] ep0ByteCount,
  input wire logic dpIn,
  input wire logic dmIn,
  output logic dpOut,
  output logic dpOe,
  output logic dmOut,
  output logic dmOe,
  output logic dualPullupEn,
  output logic busPullupEn
);

  // ----------------------------------------------------------------
  // Reset release and helpers.
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstN;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstN = rstSync[1];

  function automatic logic regHit(input logic [APB_ADDR_W-1:0] addr, input logic [5:0] idx);
    regHit = (addr[APB_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------
  logic access;
  logic wrAcc;
  logic rdAcc;
  logic selGlobal;
  logic selManual;
  logic selPin;
  logic selEpCtrl;
  logic selEpCnt;
  logic mapped;

  assign access = psel && penable && clkEn;
  assign wrAcc = access && pwrite;
  assign rdAcc = access && !pwrite;
  assign selGlobal = regHit(paddr, IDX_USB_GLOBAL_CONTROL);
  assign selManual = regHit(paddr, IDX_LINE_MANUAL_CONTROL);
  assign selPin = regHit(paddr, IDX_LINE_PIN_CONFIG);
  assign selEpCtrl = regHit(paddr, IDX_ENDPOINT0_CONTROL);
  assign selEpCnt = regHit(paddr, IDX_ENDPOINT0_COUNT);
  assign mapped = selGlobal || selManual || selPin || selEpCtrl || selEpCnt;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Line input synchronisers.
  // ----------------------------------------------------------------
  logic dpMeta;
  logic dmMeta;
  logic dpSync;
  logic dmSync;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      dpMeta <= RST_LINE_LEVEL;
      dmMeta <= RST_LINE_LEVEL;
      dpSync <= RST_LINE_LEVEL;
      dmSync <= RST_LINE_LEVEL;
    end else if (clkEn) begin
      dpMeta <= dpIn;
      dmMeta <= dmIn;
      dpSync <= dpMeta;
      dmSync <= dmMeta;
    end
  end

  logic rxDiff;
  assign rxDiff = dpSync && !dmSync;

  // ----------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------
  logic [7:0] globalCtrl;
  logic [2:0] manualCtrl;
  logic [5:0] pinCfg;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      globalCtrl <= RST_GLOBAL_CONTROL;
      manualCtrl <= RST_MANUAL_CONTROL;
      pinCfg <= RST_PIN_CONFIG;
    end else begin
      if (wrAcc && selGlobal) begin
        globalCtrl <= pwdata[7:0];
      end
      if (wrAcc && selManual) begin
        manualCtrl <= pwdata[7:5];
      end
      if (wrAcc && selPin) begin
        pinCfg <= pwdata[7:2];
      end
    end
  end

  logic usbEnable;
  logic [6:0] devAddr;
  logic manualTx;
  logic forceSe0;
  logic lineState;
  logic pinMode;
  logic openDrain;
  logic dpDrive;
  logic dmDrive;

  assign usbEnable = globalCtrl[GC_ENABLE];
  assign devAddr = globalCtrl[6:0];
  assign manualTx = manualCtrl[MC_TX_ENABLE-5];
  assign forceSe0 = manualCtrl[MC_FORCE_SE0-5];
  assign lineState = manualCtrl[MC_LINE_STATE-5];
  assign pinMode = pinCfg[PC_PIN_MODE-2];
  assign openDrain = pinCfg[PC_DRIVE_STYLE-2];
  assign dpDrive = pinCfg[PC_DPLUS_DRIVE-2];
  assign dmDrive = pinCfg[PC_DMINUS_DRIVE-2];
  assign dualPullupEn = pinCfg[PC_DUAL_PULLUP-2];
  assign busPullupEn = pinCfg[PC_BUS_PULLUP-2];

  // ----------------------------------------------------------------
  // Token acceptance.
  // ----------------------------------------------------------------
  logic hit;
  assign hit = usbEnable && tokenValid && (tokenAddr == devAddr) && tokenEp0;
  assign engineRespond = hit;

  // ----------------------------------------------------------------
  // Endpoint 0 status and configuration.
  // ----------------------------------------------------------------
  logic setupFlag;
  logic inFlag;
  logic outFlag;
  logic ackedFlag;
  logic dataValid;
  logic clrCtrl;
  logic clrCnt;
  logic [3:0] shownFlags;

  assign clrCtrl = rdAcc && selEpCtrl;
  assign clrCnt = rdAcc && selEpCnt;
  assign shownFlags = clrCtrl ? prdata[EC_SETUP:EC_ACKED] : 4'h0;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      setupFlag <= 1'b0;
      inFlag <= 1'b0;
      outFlag <= 1'b0;
      ackedFlag <= 1'b0;
    end else if (clkEn) begin
      setupFlag <= (hit && evSetupAck) || (setupFlag && !shownFlags[3]);
      inFlag <= (hit && evInToken) || (inFlag && !shownFlags[2]);
      outFlag <= (hit && evOutPacket) || (outFlag && !shownFlags[1]);
      ackedFlag <= (hit && evOutAck) || (ackedFlag && !shownFlags[0]);
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      dataValid <= 1'b0;
    end else if (clkEn) begin
      if (hit && evXferDone) begin
        dataValid <= evXferOk;
      end else if (clrCnt && prdata[CN_VALID]) begin
        dataValid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ep0Mode <= RST_EP0_MODE;
      ep0ByteCount <= RST_EP0_COUNT;
      ep0Toggle <= 1'b0;
    end else if (clkEn) begin
      if (hit && modeLoad) begin
        ep0Mode <= modeValue;
      end else if (wrAcc && selEpCtrl) begin
        ep0Mode <= pwdata[3:0];
      end
      if (hit && countLoad) begin
        ep0ByteCount <= countValue;
      end else if (wrAcc && selEpCnt) begin
        ep0ByteCount <= pwdata[3:0];
      end
      if (hit && toggleLoad) begin
        ep0Toggle <= toggleValue;
      end else if (wrAcc && selEpCnt) begin
        ep0Toggle <= pwdata[CN_TOGGLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Line drive selection.
  // ----------------------------------------------------------------
  usc_owner_t owner;
  logic wantDp;
  logic wantDm;
  logic wantEn;

  assign owner = manualTx ? USC_OWNER_MANUAL : (pinMode ? USC_OWNER_PINCFG : USC_OWNER_ENGINE);

  always_comb begin
    wantDp = sieDpOut;
    wantDm = sieDmOut;
    wantEn = sieDriveEn;
    unique case (owner)
      USC_OWNER_ENGINE: begin
        wantDp = sieDpOut;
        wantDm = sieDmOut;
        wantEn = sieDriveEn;
      end
      USC_OWNER_MANUAL: begin
        wantDp = !forceSe0 && lineState;
        wantDm = !forceSe0 && !lineState;
        wantEn = 1'b1;
      end
      USC_OWNER_PINCFG: begin
        wantDp = dpDrive;
        wantDm = dmDrive;
        wantEn = 1'b1;
      end
      default: begin
        wantEn = 1'b0;
      end
    endcase
  end

  assign dpOut = wantDp;
  assign dmOut = wantDm;
  assign dpOe = wantEn && (!openDrain || !wantDp);
  assign dmOe = wantEn && (!openDrain || !wantDm);

  // ----------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------
  logic [7:0] rdGlobal;
  logic [7:0] rdManual;
  logic [7:0] rdPin;
  logic [7:0] rdEpCtrl;
  logic [7:0] rdEpCnt;
  logic [7:0] rdByte;

  assign rdGlobal = globalCtrl;
  assign rdManual = {manualCtrl, 4'h0, rxDiff};
  assign rdPin = {pinCfg, dpSync, dmSync};
  assign rdEpCtrl = {setupFlag, inFlag, outFlag, ackedFlag, ep0Mode};
  assign rdEpCnt = {ep0Toggle, dataValid, 2'b00, ep0ByteCount};
  assign rdByte = selGlobal ? rdGlobal :
                  selManual ? rdManual :
                  selPin ? rdPin :
                  selEpCtrl ? rdEpCtrl :
                  selEpCnt ? rdEpCnt : 8'h00;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prdata <= 32'h0000_0000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rdByte};
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  AST_ENABLE_GATES: assert property (@(posedge clock) disable iff (!rstN)
    !usbEnable |-> !engineRespond) else $error("Engine answered while disabled.");
  AST_ADDR_MATCH: assert property (@(posedge clock) disable iff (!rstN)
    engineRespond |-> (tokenAddr == globalCtrl[6:0])) else $error("Engine answered wrong address.");
  AST_ENGINE_OWNS: assert property (@(posedge clock) disable iff (!rstN)
    (!manualCtrl[2] && !pinCfg[5]) |-> (dpOut == sieDpOut && dmOut == sieDmOut))
    else $error("Engine lost the lines.");
  AST_SE0: assert property (@(posedge clock) disable iff (!rstN)
    (manualCtrl[2] && manualCtrl[1]) |-> (!dpOut && !dmOut && dpOe && dmOe))
    else $error("Forced SE0 not driven.");
  AST_JK: assert property (@(posedge clock) disable iff (!rstN)
    (manualCtrl[2] && !manualCtrl[1]) |-> (dpOut == manualCtrl[0] && dmOut == !manualCtrl[0]))
    else $error("Manual J or K wrong.");
  AST_PIN_MODE: assert property (@(posedge clock) disable iff (!rstN)
    (!manualCtrl[2] && pinCfg[5]) |-> (dpOut == pinCfg[3] && dmOut == pinCfg[2]))
    else $error("Pin drive bits not applied.");
  AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (!rstN)
    (pinCfg[4] && dpOut) |-> !dpOe) else $error("Open drain drove high.");
  AST_RECEIVER: assert property (@(posedge clock) disable iff (!rstN)
    ($past(clkEn) && $past(clkEn, 2)) |-> (rxDiff == ($past(dpIn, 2) && !$past(dmIn, 2))))
    else $error("Receiver bit wrong.");
  AST_SETUP_SET: assert property (@(posedge clock) disable iff (!rstN)
    (clkEn && hit && evSetupAck) |=> setupFlag) else $error("Setup flag not set.");
  AST_READ_CLEAR: assert property (@(posedge clock) disable iff (!rstN)
    (clrCtrl && prdata[EC_IN] && !(hit && evInToken)) |=> !inFlag)
    else $error("IN flag not cleared.");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!rstN)
    (clrCtrl && hit && evOutPacket) |=> outFlag) else $error("Event lost to read.");
  AST_ACKED_CAUSE: assert property (@(posedge clock) disable iff (!rstN)
    $rose(ackedFlag) |-> $past(hit && evOutAck)) else $error("Acked flag without cause.");

  COV_SETUP: cover property (@(posedge clock) disable iff (!rstN) $rose(setupFlag));
  COV_CLEAR_RACE: cover property (@(posedge clock) disable iff (!rstN) clrCtrl && hit);
  COV_MANUAL_K: cover property (@(posedge clock) disable iff (!rstN)
    manualTx && !forceSe0 && !lineState);
  COV_OPEN_DRAIN: cover property (@(posedge clock) disable iff (!rstN) pinMode && openDrain);

endmodule // usc_sie_control

/* File: dv/usc_host_model.sv */
module usc_host_model
  import usc_pkg::*;
(
  input wire logic clock,
  input wire logic engineRespond,
  input wire logic dpOut,
  input wire logic dpOe,
  input wire logic dmOut,
  input wire logic dmOe,
  input wire logic dualPullupEn,
  input wire logic busPullupEn,
  output logic tokenValid,
  output logic [6:0] tokenAddr,
  output logic tokenEp0,
  output logic evSetupAck,
  output logic evInToken,
  output logic evOutPacket,
  output logic evOutAck,
  output logic evXferDone,
  output logic evXferOk,
  output logic modeLoad,
  output logic [3:0] modeValue,
  output logic countLoad,
  output logic [3:0] countValue,
  output logic toggleLoad,
  output logic toggleValue,
  output logic sieDpOut,
  output logic sieDmOut,
  output logic sieDriveEn,
  output logic dpIn,
  output logic dmIn
);
  // ----------------------------------------------------------------
  // Line levels and engine traffic.
  // ----------------------------------------------------------------
  logic hit;

  // An undriven line falls to the host pull-down unless a pull-up is on; the bus pull-up lifts only D+, the dual pull-up both lines.
  assign dpIn = dpOe ? dpOut : (busPullupEn | dualPullupEn);
  assign dmIn = dmOe ? dmOut : dualPullupEn;

  initial begin
    hit = 1'b0;
    {tokenValid, tokenEp0, evSetupAck, evInToken, evOutPacket, evOutAck} = 6'h00;
    {evXferDone, evXferOk, modeLoad, countLoad, toggleLoad, toggleValue} = 6'h00;
    {tokenAddr, modeValue, countValue} = 15'h0000;
    {sieDriveEn, sieDpOut, sieDmOut} = 3'b111;
  end

  task automatic line(input logic [2:0] v);
    @(posedge clock);
    {sieDriveEn, sieDpOut, sieDmOut} <= v;
  endtask

  // Presents one token for a cycle with its events; on release address, endpoint, mode and count values flip, evXferOk holds, other events and loads drop.
  task automatic strobe(input logic [6:0] a, input logic [14:0] f);
    @(posedge clock);
    tokenValid <= 1'b1;
    tokenAddr <= a;
    tokenEp0 <= f[14];
    {evXferDone, evSetupAck, evInToken, evOutPacket, evOutAck} <= f[4:0];
    evXferOk <= f[5];
    {toggleValue, toggleLoad, countLoad, modeLoad} <= f[9:6];
    modeValue <= f[13:10];
    countValue <= f[13:10];
    @(negedge clock);
    hit = engineRespond;
    @(posedge clock);
    tokenValid <= 1'b0;
    tokenAddr <= ~a;
    tokenEp0 <= ~f[14];
    {evXferDone, evSetupAck, evInToken, evOutPacket, evOutAck} <= 5'h00;
    {toggleValue, toggleLoad, countLoad, modeLoad} <= 4'h0;
    modeValue <= ~f[13:10];
    countValue <= ~f[13:10];
  endtask
endmodule // usc_host_model

/* File: dv/usc_sie_control_bench.sv */
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end

module usc_sie_control_bench
  import usc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, engineRespond, ep0Toggle, dpOut, dpOe, dmOut, dmOe;
  logic dualPullupEn, busPullupEn, tokenValid, tokenEp0, evSetupAck, evInToken;
  logic evOutPacket, evOutAck, evXferDone, evXferOk, modeLoad, countLoad, toggleLoad;
  logic toggleValue, sieDpOut, sieDmOut, sieDriveEn, dpIn, dmIn, lastErr;
  logic [6:0] tokenAddr;
  logic [3:0] modeValue, countValue, ep0Mode, ep0ByteCount;
  int failures = 0, checked = 0;
  localparam logic [7:0] A_GC = {IDX_USB_GLOBAL_CONTROL, 2'b00};
  localparam logic [7:0] A_MC = {IDX_LINE_MANUAL_CONTROL, 2'b00};
  localparam logic [7:0] A_PC = {IDX_LINE_PIN_CONFIG, 2'b00};
  localparam logic [7:0] A_EC = {IDX_ENDPOINT0_CONTROL, 2'b00};
  localparam logic [7:0] A_CN = {IDX_ENDPOINT0_COUNT, 2'b00};
  localparam logic [6:0] DEV = 7'h2a;

  usc_sie_control dut (.*);
  usc_host_model host (.*);

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus tasks.
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    apb(1'b0, a, 8'h00, r);
    `CHK(n, e, r)
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd("gc", A_GC, RST_GLOBAL_CONTROL);
    `CHK("ok", 1'b0, lastErr)
    rd("mc", A_MC, 8'h00);
    rd("pc", A_PC, 8'h03);
    rd("ec", A_EC, 8'h00);
    rd("cn", A_CN, 8'h00);
    wr(8'he0, 8'h5a);
    rd("hole", 8'he0, 8'h00);
    `CHK("err", 1'b1, lastErr)
  endtask

  task automatic t_enable();
    wr(A_GC, {1'b0, DEV});
    host.strobe(DEV, 15'h4008);
    `CHK("off", 1'b0, host.hit)
    rd("offflag", A_EC, 8'h00);
    wr(A_GC, {1'b1, DEV});
    rd("gc", A_GC, {1'b1, DEV});
    host.strobe(DEV, 15'h4000);
    `CHK("hit", 1'b1, host.hit)
    host.strobe(DEV ^ 7'h40, 15'h4000);
    `CHK("miss6", 1'b0, host.hit)
    host.strobe(DEV ^ 7'h01, 15'h4008);
    `CHK("miss0", 1'b0, host.hit)
    host.strobe(DEV, 15'h0008);
    `CHK("ep1", 1'b0, host.hit)
    rd("missflag", A_EC, 8'h00);
  endtask

  // Each row holds manual control, pin config and the expected pin drive.
  task automatic t_lines();
    logic [19:0] row;
    logic [19:0] tbl [12];
    tbl = '{20'h0000f, 20'h4000f, 20'h2000f, 20'hc0005, 20'he0005, 20'h80007,
            20'ha000d, 20'h00a0d, 20'h00907, 20'h00e01, 20'h00d04, 20'ha090d};
    host.line(3'b111);
    foreach (tbl[i]) begin
      row = tbl[i];
      wr(A_PC, row[11:4]);
      wr(A_MC, row[19:12]);
      repeat (4) @(posedge clock);
      `CHK("pins", row[3:0], {dpOut & dpOe, dpOe, dmOut & dmOe, dmOe})
      rd("rx", A_MC, row[19:12] | {7'h00, row[3] & ~row[1]});
      rd("lvl", A_PC, row[11:4] | {6'h00, row[3], row[1]});
    end
  endtask

  task automatic t_pullups();
    logic [7:0] pv [4];
    pv = '{8'h04, 8'h08, 8'h0c, 8'h00};
    wr(A_MC, 8'h00);
    host.line(3'b000);
    foreach (pv[i]) begin
      wr(A_PC, pv[i]);
      repeat (4) @(posedge clock);
      `CHK("bus", pv[i][2], busPullupEn)
      `CHK("dual", pv[i][3], dualPullupEn)
      rd("pull", A_PC, pv[i] | {6'h00, pv[i][2] | pv[i][3], pv[i][3]});
    end
  endtask

  task automatic t_flags();
    clkEn <= 1'b0;
    host.strobe(DEV, 15'h4008);
    clkEn <= 1'b1;
    rd("frozen", A_EC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.strobe(DEV, 15'h4000 | (15'h0008 >> i));
      rd("flag", A_EC, 8'h80 >> i);
      rd("clear", A_EC, 8'h00);
    end
    fork
      rd("race", A_EC, 8'h00);
      begin
        @(posedge clock);
        host.strobe(DEV, 15'h4006);
      end
    join
    rd("kept", A_EC, 8'h60);
    fork
      rd("early", A_EC, 8'h00);
      host.strobe(DEV, 15'h4008);
    join
    rd("held", A_EC, 8'h80);
  endtask

  task automatic t_fields();
    host.strobe(DEV, 15'h5440);
    @(negedge clock);
    `CHK("mode", 4'h5, ep0Mode)
    rd("emode", A_EC, 8'h05);
    wr(A_EC, 8'h0a);
    rd("wmode", A_EC, 8'h0a);
    wr(A_CN, 8'h8c);
    @(negedge clock);
    `CHK("tog", 1'b1, ep0Toggle)
    `CHK("cnt", 4'hc, ep0ByteCount)
    rd("wcnt", A_CN, 8'h8c);
    host.strobe(DEV, 15'h4d80);
    rd("ecnt", A_CN, 8'h03);
    host.strobe(DEV, 15'h4030);
    rd("valid", A_CN, 8'h43);
    rd("vclear", A_CN, 8'h03);
    host.strobe(DEV, 15'h4030);
    host.strobe(DEV, 15'h4010);
    rd("bad", A_CN, 8'h03);
  endtask

  // ----------------------------------------------------------------
  // Run control.
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_enable();
    t_lines();
    t_pullups();
    t_flags();
    t_fields();
    complete_run();
  end

  initial begin
    #2000000;
    failures++;
    complete_run();
  end
endmodule // usc_sie_control_bench
